//--- smpg_guard.sv
// monitor outputs and position error protection of a servo drive
// What this block does
// - each monitor outputs minus (selected signal times multiplier plus offset)
// - each monitor drives a 16-bit converter word, linear within plus minus 8 V
// - signed offset per channel, -10000..10000 in 0.1 V, reset 0, immediate
// - signed multiplier per channel, -10000..10000 in 0.01, reset 100, immediate
// - position error is reference position minus actual motor position
// - excessive error check works only in position control mode
// - error above the alarm level raises overflow alarm and stops motor
// - alarm level 1..1073741823, reset 5242880, immediate
// - power on with residual error moves motor until error cleared
// - servo-on error level 1..1073741823, reset 5242880, immediate
// - servo-on speed limit 0..10000 rpm, reset 10000, immediate
// - power on with error above servo-on level raises servo-on alarm
// - limited and references arriving with error above level raises own alarm
// - channel 1 and 2 each have a selection setting, codes 00..0D
`timescale 1ns/1ns
module smpg_guard
  import smpg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // drive side
  input wire logic [31:0] motor_pos_i,
  input wire logic [SMPG_NSIG-1:0][15:0] mon_sig_i,
  // outputs
  output logic [15:0] monitor1_dac_o,
  output logic [15:0] monitor2_dac_o,
  output logic motor_enable_o,
  output logic motor_stop_o,
  output logic speed_limit_active_o,
  output logic [13:0] speed_limit_o,
  output logic irq_o
);
  // merge byte lanes into an old word
  function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] din,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction : apply_sel

  // clamp a signed setting into -10000..10000
  function automatic logic signed [15:0] clamp_set(input logic [31:0] v);
    logic signed [31:0] s;
    s = $signed(v);
    if (s > 32'(SMPG_SET_MAX))
    begin
      return SMPG_SET_MAX;
    end
    else if (s < 32'(SMPG_SET_MIN))
    begin
      return SMPG_SET_MIN;
    end
    return s[15:0];
  endfunction : clamp_set

  // clamp an error level into 1..1073741823
  function automatic logic [31:0] clamp_level(input logic [31:0] v);
    if (v < SMPG_LEVEL_MIN)
    begin
      return SMPG_LEVEL_MIN;
    end
    else if (v > SMPG_LEVEL_MAX)
    begin
      return SMPG_LEVEL_MAX;
    end
    return v;
  endfunction : clamp_level

  // settings and state
  logic power_reg, power_next;
  smpg_mode_t mode_reg, mode_next;
  logic [3:0] sel_reg [2], sel_next [2];
  logic signed [15:0] offset_reg [2], offset_next [2];
  logic signed [15:0] mult_reg [2], mult_next [2];
  logic [31:0] err_level_reg, err_level_next;
  logic [31:0] son_level_reg, son_level_next;
  logic [13:0] son_speed_reg, son_speed_next;
  logic [31:0] pos_ref_reg, pos_ref_next;
  logic [SMPG_ST_W-1:0] status_reg, status_next;
  logic [SMPG_ST_W-1:0] mask_reg, mask_next;
  logic [SMPG_ST_W-1:0] alarm_reg, alarm_next;
  logic limit_reg, limit_next;
  logic ref_seen_reg, ref_seen_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  // helpers
  logic req;
  logic wr;
  logic rd;
  logic ref_wr;
  logic [31:0] wdat;
  logic signed [31:0] pos_err;
  logic [31:0] err_mag;
  logic power_rise;
  logic ovf_hit;
  logic son_hit;
  logic spd_hit;
  logic [SMPG_ST_W-1:0] events;
  logic [15:0] mon_out [2];
  logic signed [15:0] err_sample;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg; // commit on the edge the master sees ack
  assign rd = req & ~wb_we_i;
  assign ref_wr = wr & (wb_adr_i == SMPG_POS_REF_OFS);

  // position error and its magnitude
  always_comb
  begin
    pos_err = $signed(pos_ref_reg - motor_pos_i);
    err_mag = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
  end

  // protection events; overflow and limit checks need position mode with power applied, the servo-on check does not
  always_comb
  begin
    // taken from the write itself; deriving it from power_next would loop through the alarm
    power_rise = wr & (wb_adr_i == SMPG_CTRL_OFS) & wdat[SMPG_CTRL_POWER_BIT] & ~power_reg
                 & (~|alarm_reg | wdat[SMPG_CTRL_ALM_CLR_BIT]);
    son_hit = power_rise & (err_mag > son_level_reg);
    ovf_hit = 1'b0;
    spd_hit = 1'b0;
    if (power_reg && (mode_reg == SMPG_MODE_POSITION) && (err_mag > err_level_reg))
    begin
      if (limit_reg && ref_seen_reg)
      begin
        spd_hit = 1'b1;
      end
      else
      begin
        ovf_hit = 1'b1;
      end
    end
    events = '0;
    events[SMPG_ST_OVF_BIT] = ovf_hit;
    events[SMPG_ST_SON_BIT] = son_hit;
    events[SMPG_ST_SPD_BIT] = spd_hit;
  end

  // register writes, alarm latch, servo-on limit and interrupt status
  always_comb
  begin
    wdat = apply_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
    power_next = power_reg;
    mode_next = mode_reg;
    sel_next = sel_reg;
    offset_next = offset_reg;
    mult_next = mult_reg;
    err_level_next = err_level_reg;
    son_level_next = son_level_reg;
    son_speed_next = son_speed_reg;
    pos_ref_next = pos_ref_reg;
    mask_next = mask_reg;
    alarm_next = alarm_reg;
    if (wr)
    begin
      case (wb_adr_i)
        SMPG_CTRL_OFS:
        begin
          power_next = wdat[SMPG_CTRL_POWER_BIT];
          mode_next = smpg_mode_t'(wdat[SMPG_CTRL_MODE_LSB +: 2]);
          if (wdat[SMPG_CTRL_ALM_CLR_BIT])
          begin
            alarm_next = '0;
          end
        end
        SMPG_MON1_SEL_OFS: sel_next[0] = (wdat[3:0] > SMPG_SEL_MAX) ? sel_reg[0] : wdat[3:0];
        SMPG_MON2_SEL_OFS: sel_next[1] = (wdat[3:0] > SMPG_SEL_MAX) ? sel_reg[1] : wdat[3:0];
        SMPG_MON1_OFFSET_OFS: offset_next[0] = clamp_set(wdat);
        SMPG_MON2_OFFSET_OFS: offset_next[1] = clamp_set(wdat);
        SMPG_MON1_MULT_OFS: mult_next[0] = clamp_set(wdat);
        SMPG_MON2_MULT_OFS: mult_next[1] = clamp_set(wdat);
        SMPG_ERR_LEVEL_OFS: err_level_next = clamp_level(apply_sel(err_level_reg, wb_dat_i, wb_sel_i));
        SMPG_SON_LEVEL_OFS: son_level_next = clamp_level(apply_sel(son_level_reg, wb_dat_i, wb_sel_i));
        SMPG_SON_SPEED_OFS:
          son_speed_next = (wdat > 32'(SMPG_SPEED_MAX)) ? SMPG_SPEED_MAX : wdat[13:0];
        SMPG_POS_REF_OFS: pos_ref_next = apply_sel(pos_ref_reg, wb_dat_i, wb_sel_i);
        SMPG_MASK_OFS: mask_next = wdat[SMPG_ST_W-1:0];
        default: ;
      endcase
    end
    // an alarm drops motor power; set wins over the clear written this cycle
    alarm_next = alarm_next | events;
    if (|alarm_next)
    begin
      power_next = 1'b0;
    end
    // servo-on limit holds until the residual error is worked off or power drops
    limit_next = limit_reg;
    ref_seen_next = ref_seen_reg;
    if (power_rise && (err_mag != 32'h0000_0000))
    begin
      limit_next = 1'b1;
      ref_seen_next = 1'b0;
    end
    else if (!power_reg || (err_mag == 32'h0000_0000))
    begin
      limit_next = 1'b0;
      ref_seen_next = 1'b0;
    end
    else if (limit_reg && ref_wr)
    begin
      ref_seen_next = 1'b1;
    end
    // read of status clears it, but an event in that cycle survives
    status_next = status_reg;
    if (rd && (wb_adr_i == SMPG_STATUS_OFS))
    begin
      status_next = '0;
    end
    status_next = status_next | events;
  end

  // bus answer: ack one cycle after the request, unmapped reads zero
  always_comb
  begin
    ack_next = req;
    rdata_next = 32'h0000_0000;
    if (rd)
    begin
      case (wb_adr_i)
        SMPG_CTRL_OFS: rdata_next = {28'h000_0000, 1'b0, mode_reg, power_reg};
        SMPG_MON1_SEL_OFS: rdata_next = {28'h000_0000, sel_reg[0]};
        SMPG_MON2_SEL_OFS: rdata_next = {28'h000_0000, sel_reg[1]};
        SMPG_MON1_OFFSET_OFS: rdata_next = 32'(offset_reg[0]);
        SMPG_MON2_OFFSET_OFS: rdata_next = 32'(offset_reg[1]);
        SMPG_MON1_MULT_OFS: rdata_next = 32'(mult_reg[0]);
        SMPG_MON2_MULT_OFS: rdata_next = 32'(mult_reg[1]);
        SMPG_ERR_LEVEL_OFS: rdata_next = err_level_reg;
        SMPG_SON_LEVEL_OFS: rdata_next = son_level_reg;
        SMPG_SON_SPEED_OFS: rdata_next = {18'h0_0000, son_speed_reg};
        SMPG_POS_REF_OFS: rdata_next = pos_ref_reg;
        SMPG_POS_ERR_OFS: rdata_next = pos_err;
        SMPG_STATUS_OFS: rdata_next = {29'h0000_0000, status_reg};
        SMPG_MASK_OFS: rdata_next = {29'h0000_0000, mask_reg};
        SMPG_MON1_OUT_OFS: rdata_next = 32'($signed(mon_out[0]));
        SMPG_MON2_OUT_OFS: rdata_next = 32'($signed(mon_out[1]));
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_reg <= 1'b0;
      mode_reg <= SMPG_MODE_POSITION;
      sel_reg[0] <= SMPG_SEL1_RST;
      sel_reg[1] <= SMPG_SEL2_RST;
      offset_reg[0] <= SMPG_OFFSET_RST;
      offset_reg[1] <= SMPG_OFFSET_RST;
      mult_reg[0] <= SMPG_MULT_RST;
      mult_reg[1] <= SMPG_MULT_RST;
      err_level_reg <= SMPG_LEVEL_RST;
      son_level_reg <= SMPG_LEVEL_RST;
      son_speed_reg <= SMPG_SPEED_RST;
      pos_ref_reg <= 32'h0000_0000;
      status_reg <= '0;
      mask_reg <= '0;
      alarm_reg <= '0;
      limit_reg <= 1'b0;
      ref_seen_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      power_reg <= power_next;
      mode_reg <= mode_next;
      sel_reg <= sel_next;
      offset_reg <= offset_next;
      mult_reg <= mult_next;
      err_level_reg <= err_level_next;
      son_level_reg <= son_level_next;
      son_speed_reg <= son_speed_next;
      pos_ref_reg <= pos_ref_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      alarm_reg <= alarm_next;
      limit_reg <= limit_next;
      ref_seen_reg <= ref_seen_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // position error as monitor code 03, clipped; reads 0 V outside position mode
  always_comb
  begin
    if (mode_reg != SMPG_MODE_POSITION)
    begin
      err_sample = 16'sh0000;
    end
    else if (pos_err > 32'sh0000_7FFF)
    begin
      err_sample = 16'sh7FFF;
    end
    else if (pos_err < -32'sh0000_8000)
    begin
      err_sample = 16'sh8000;
    end
    else
    begin
      err_sample = pos_err[15:0];
    end
  end

  // two identical monitor channels
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_mon
    smpg_mon_if mon_bus ();
    assign mon_bus.sample = (sel_reg[ch] == SMPG_SEL_POS_ERR) ? err_sample
                            : $signed(mon_sig_i[sel_reg[ch]]);
    assign mon_bus.mult = mult_reg[ch];
    assign mon_bus.offset = offset_reg[ch];
    assign mon_out[ch] = mon_bus.result;
    smpg_mon_scale u_scale (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mon(mon_bus.scaler)
    );
  end

  // outputs
  assign monitor1_dac_o = mon_out[0];
  assign monitor2_dac_o = mon_out[1];
  assign motor_enable_o = power_reg;
  assign motor_stop_o = |alarm_reg;
  assign speed_limit_active_o = limit_reg;
  assign speed_limit_o = son_speed_reg;
  assign irq_o = |(status_reg & mask_reg);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
endmodule : smpg_guard

//--- smpg_guard_checker.sv
// concurrent checks on the guard's bus, alarm and limit outputs
`timescale 1ns/1ns
module smpg_guard_checker
  import smpg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // drive outputs
  input wire logic motor_enable_o,
  input wire logic motor_stop_o,
  input wire logic speed_limit_active_o,
  input wire logic [13:0] speed_limit_o,
  input wire logic irq_o
);
  logic clr_req;
  // alarm clear write; only this may end a latched stop
  assign clr_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == SMPG_CTRL_OFS
    && wb_sel_i[0] && wb_dat_i[SMPG_CTRL_ALM_CLR_BIT];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // request, then a single-cycle answer
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence bus_ans;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_answer_a: assert property (bus_req |-> bus_ans)
    else $error("bus request not answered in one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  stop_power_a:
    assert property (motor_stop_o |-> !motor_enable_o) else $error("power on during alarm");
  stop_hold_a:
    assert property ($fell(motor_stop_o) |-> $past(clr_req) || $past(clr_req, 2))
    else $error("alarm dropped without clear");
  irq_alarm_a:
    assert property ($rose(irq_o) |-> ##[0:1] motor_stop_o) else $error("irq without alarm");
  speed_clamp_a:
    assert property (speed_limit_o <= SMPG_SPEED_MAX) else $error("speed limit out of range");
  limit_drop_a:
    assert property (!motor_enable_o |-> ##[0:2] !speed_limit_active_o)
    else $error("speed limit kept with power off");
endmodule : smpg_guard_checker
bind smpg_guard smpg_guard_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .motor_enable_o, .motor_stop_o,
  .speed_limit_active_o, .speed_limit_o, .irq_o);

//--- smpg_guard_tb.sv
// self-checking bench of the monitor and position error guard
`timescale 1ns/1ns
module smpg_guard_tb
  import smpg_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stall = 1, ld = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, tgt = 0, ldv = 0, seed = 32'h0000_0dad, e;
  logic [SMPG_NSIG-1:0][15:0] sig = '0;
  logic [31:0] rq[$];
  wire logic [31:0] rdat, pos;
  wire logic ack, men, mstop, lim, irq;
  wire logic [15:0] d1, d2;
  wire logic [13:0] spd;
  int num_errors = 0, n_checks = 0;
  logic [7:0] ra [15] = '{SMPG_CTRL_OFS, SMPG_MON1_SEL_OFS, SMPG_MON2_SEL_OFS,
    SMPG_MON1_OFFSET_OFS, SMPG_MON2_OFFSET_OFS, SMPG_MON1_MULT_OFS, SMPG_MON2_MULT_OFS,
    SMPG_ERR_LEVEL_OFS, SMPG_SON_LEVEL_OFS, SMPG_SON_SPEED_OFS, SMPG_POS_REF_OFS,
    SMPG_POS_ERR_OFS, SMPG_STATUS_OFS, SMPG_MASK_OFS, 8'h40};
  logic [31:0] rv [15] = '{32'h0000_0002, 32'h0000_0002, 0, 0, 0, 32'h0000_0064,
    32'h0000_0064, 32'h0050_0000, 32'h0050_0000, 32'h0000_2710, 0, 0, 0, 0, 0};
  smpg_guard dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .motor_pos_i(pos), .mon_sig_i(sig), .monitor1_dac_o(d1), .monitor2_dac_o(d2),
    .motor_enable_o(men), .motor_stop_o(mstop), .speed_limit_active_o(lim),
    .speed_limit_o(spd), .irq_o(irq));
  smpg_motor_model motor (.clk_i, .rst_i, .run_i(men && !stall), .ld_i(ld),
    .ld_val_i(ldv), .tgt_i(tgt), .pos_o(pos));
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected converter word, clipped instead of wrapped
  function automatic logic [15:0] mexp(input int s, input int m, input int o);
    int v;
    v = -((s * m) / int'(SMPG_MULT_UNITY) + o * int'(SMPG_OFFSET_CODES));
    if (v > int'(SMPG_DAC_MAX))
      v = int'(SMPG_DAC_MAX);
    if (v < int'(SMPG_DAC_MIN))
      v = int'(SMPG_DAC_MIN);
    return v[15:0];
  endfunction : mexp
  // code 3 is the position error, held at zero while monitoring
  function automatic int smp(input int k);
    return (k == 3) ? 0 : int'($signed(sig[k]));
  endfunction : smp
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // classic cycle; the request is held until ack is sampled, no latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    for (n = 0; n < 20 && !ack; n++)
      @(posedge clk_i);
    if (!ack)
    begin
      num_errors++;
      close_out();
    end
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    wb(0, a, 0);
  endtask : rd
  task automatic pst(input logic [3:0] x);
    repeat (3) @(posedge clk_i);
    chk("stop enable limit irq", x, {mstop, men, lim, irq});
  endtask : pst
  // read results are matched against the oldest note
  always @(posedge clk_i)
    if (ack && !we)
    begin
      e = rq.pop_front();
      chk("read data", e, rdat);
    end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(1, 8'h40, 32'hffff_ffff);
    for (int i = 0; i < 15; i++)
      rd(ra[i], rv[i]);
    chk("speed limit", 32'h0000_2710, spd);
    // out-of-range settings are clipped, bad codes kept out
    wb(1, SMPG_MON1_MULT_OFS, 32'h0000_4e20);
    rd(SMPG_MON1_MULT_OFS, 32'h0000_2710);
    wb(1, SMPG_MON2_OFFSET_OFS, 32'hffff_b1e0);
    rd(SMPG_MON2_OFFSET_OFS, 32'hffff_d8f0);
    wb(1, SMPG_ERR_LEVEL_OFS, 0);
    rd(SMPG_ERR_LEVEL_OFS, 32'h0000_0001);
    wb(1, SMPG_SON_LEVEL_OFS, 32'h4000_0000);
    rd(SMPG_SON_LEVEL_OFS, 32'h3fff_ffff);
    wb(1, SMPG_MON1_SEL_OFS, 32'h0000_000d);
    wb(1, SMPG_MON1_SEL_OFS, 32'h0000_000e);
    rd(SMPG_MON1_SEL_OFS, 32'h0000_000d);
    wb(1, SMPG_SON_SPEED_OFS, 32'h0000_4e20);
    rd(SMPG_SON_SPEED_OFS, 32'h0000_2710);
    wb(1, SMPG_SON_SPEED_OFS, 32'h0000_04d2);
    repeat (2) @(posedge clk_i);
    chk("speed limit", 32'h0000_04d2, spd);
    // every signal code on both channels with random gain and offset
    for (int k = 0; k < 14; k++)
    begin
      int m1, m2, o1, o2;
      m1 = int'(xs() % 20001) - 10000;
      m2 = int'(xs() % 20001) - 10000;
      o1 = int'(xs() % 201) - 100;
      o2 = int'(xs() % 201) - 100;
      sig <= {xs(), xs(), xs(), xs(), xs(), xs(), xs()};
      wb(1, SMPG_MON1_SEL_OFS, 32'(k));
      wb(1, SMPG_MON2_SEL_OFS, 32'(13 - k));
      wb(1, SMPG_MON1_MULT_OFS, 32'(m1));
      wb(1, SMPG_MON2_MULT_OFS, 32'(m2));
      wb(1, SMPG_MON1_OFFSET_OFS, 32'(o1));
      wb(1, SMPG_MON2_OFFSET_OFS, 32'(o2));
      repeat (3) @(posedge clk_i);
      chk("monitor 1", mexp(smp(k), m1, o1), d1);
      chk("monitor 2", mexp(smp(13 - k), m2, o2), d2);
    end
    // stalled shaft 100 counts behind the reference
    wb(1, SMPG_MASK_OFS, 32'h0000_0007);
    ldv <= 32'hffff_ff9c;
    ld <= 1;
    @(posedge clk_i);
    ld <= 0;
    wb(1, SMPG_ERR_LEVEL_OFS, 32'h0000_0032);
    wb(1, SMPG_SON_LEVEL_OFS, 32'h0000_00c8);
    wb(1, SMPG_CTRL_OFS, 32'h0000_0005);
    pst(4'b0110);
    rd(SMPG_POS_ERR_OFS, 32'h0000_0064);
    wb(1, SMPG_CTRL_OFS, 32'h0000_0003);
    pst(4'b1001);
    rd(SMPG_STATUS_OFS, 32'h0000_0001);
    rd(SMPG_STATUS_OFS, 32'h0000_0000);
    pst(4'b1000);
    wb(1, SMPG_CTRL_OFS, 32'h0000_000a);
    pst(4'b0000);
    // power-on alarm, first masked then unmasked
    wb(1, SMPG_MASK_OFS, 0);
    wb(1, SMPG_SON_LEVEL_OFS, 32'h0000_0032);
    wb(1, SMPG_ERR_LEVEL_OFS, 32'h0000_03e8);
    wb(1, SMPG_CTRL_OFS, 32'h0000_0003);
    pst(4'b1000);
    wb(1, SMPG_MASK_OFS, 32'h0000_0002);
    pst(4'b1001);
    rd(SMPG_STATUS_OFS, 32'h0000_0002);
    wb(1, SMPG_CTRL_OFS, 32'h0000_000a);
    // reference arrives while the power-on speed limit holds
    wb(1, SMPG_SON_LEVEL_OFS, 32'h0000_03e8);
    wb(1, SMPG_MASK_OFS, 32'h0000_0007);
    wb(1, SMPG_CTRL_OFS, 32'h0000_0003);
    pst(4'b0110);
    tgt <= 32'h0000_07d0;
    wb(1, SMPG_POS_REF_OFS, 32'h0000_07d0);
    pst(4'b1001);
    rd(SMPG_STATUS_OFS, 32'h0000_0004);
    wb(1, SMPG_CTRL_OFS, 32'h0000_000a);
    // free shaft drains the residual error, then the limit lifts
    stall <= 0;
    wb(1, SMPG_ERR_LEVEL_OFS, 32'h0000_1388);
    wb(1, SMPG_SON_LEVEL_OFS, 32'h0000_1388);
    wb(1, SMPG_CTRL_OFS, 32'h0000_0003);
    for (int n = 0; n < 3000 && lim; n++)
      @(posedge clk_i);
    if (lim)
    begin
      num_errors++;
      close_out();
    end
    rd(SMPG_POS_ERR_OFS, 0);
    pst(4'b0100);
    close_out();
  end
endmodule : smpg_guard_tb

//--- smpg_mon_if.sv
// carrier between the guard core and one monitor scaler
`timescale 1ns/1ns
interface smpg_mon_if;
  logic signed [15:0] sample;
  logic signed [15:0] mult;
  logic signed [15:0] offset;
  logic signed [15:0] result;
  modport core (output sample, output mult, output offset, input result);
  modport scaler (input sample, input mult, input offset, output result);
endinterface : smpg_mon_if

//--- smpg_mon_scale.sv
// one analog monitor channel: scale, offset, negate, saturate
`timescale 1ns/1ns
module smpg_mon_scale
  import smpg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // channel carrier
  smpg_mon_if.scaler mon
);
  logic signed [31:0] prod_reg, prod_next;
  logic signed [31:0] ofs_reg, ofs_next;
  logic signed [15:0] out_reg, out_next;
  logic signed [31:0] scaled;
  logic signed [31:0] total;

  // two stages keep the multiplier and divider off one path
  always_comb
  begin
    prod_next = 32'(mon.sample) * 32'(mon.mult); // widen first so the product is not cut to 16
    ofs_next = 32'(mon.offset) * SMPG_OFFSET_CODES;
    scaled = prod_reg / $signed(SMPG_MULT_UNITY);
    total = -(scaled + ofs_reg);
    if (total > SMPG_DAC_MAX)
    begin
      out_next = SMPG_DAC_MAX[15:0];
    end
    else if (total < SMPG_DAC_MIN)
    begin
      out_next = SMPG_DAC_MIN[15:0];
    end
    else
    begin
      out_next = total[15:0];
    end
  end

  // result register feeds the converter word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prod_reg <= 32'sh0000_0000;
      ofs_reg <= 32'sh0000_0000;
      out_reg <= 16'sh0000;
    end
    else
    begin
      prod_reg <= prod_next;
      ofs_reg <= ofs_next;
      out_reg <= out_next;
    end
  end

  assign mon.result = out_reg;
endmodule : smpg_mon_scale

//--- smpg_motor_model.sv
// behavioural motor shaft that steps toward the reference while powered
`timescale 1ns/1ns
module smpg_motor_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic ld_i,
  input wire logic [31:0] ld_val_i,
  input wire logic [31:0] tgt_i,
  // encoder position
  output logic [31:0] pos_o
);
  logic [31:0] pos_reg;
  logic [31:0] pos_next;
  // one count a cycle, so a residual error drains slowly and visibly
  always_comb
  begin
    pos_next = pos_reg;
    if (ld_i)
      pos_next = ld_val_i;
    else if (run_i && pos_reg != tgt_i)
      pos_next = ($signed(tgt_i - pos_reg) > 0) ? pos_reg + 1 : pos_reg - 1;
  end
  // position register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pos_reg <= 32'h0000_0000;
    else
      pos_reg <= pos_next;
  end
  assign pos_o = pos_reg;
endmodule : smpg_motor_model

//--- smpg_pkg.sv
// shared constants of the servo monitor and position error guard
package smpg_pkg;
  // register byte offsets
  localparam logic [7:0] SMPG_CTRL_OFS = 8'h00;
  localparam logic [7:0] SMPG_MON1_SEL_OFS = 8'h04;
  localparam logic [7:0] SMPG_MON2_SEL_OFS = 8'h08;
  localparam logic [7:0] SMPG_MON1_OFFSET_OFS = 8'h0C;
  localparam logic [7:0] SMPG_MON2_OFFSET_OFS = 8'h10;
  localparam logic [7:0] SMPG_MON1_MULT_OFS = 8'h14;
  localparam logic [7:0] SMPG_MON2_MULT_OFS = 8'h18;
  localparam logic [7:0] SMPG_ERR_LEVEL_OFS = 8'h1C;
  localparam logic [7:0] SMPG_SON_LEVEL_OFS = 8'h20;
  localparam logic [7:0] SMPG_SON_SPEED_OFS = 8'h24;
  localparam logic [7:0] SMPG_POS_REF_OFS = 8'h28;
  localparam logic [7:0] SMPG_POS_ERR_OFS = 8'h2C;
  localparam logic [7:0] SMPG_STATUS_OFS = 8'h30;
  localparam logic [7:0] SMPG_MASK_OFS = 8'h34;
  localparam logic [7:0] SMPG_MON1_OUT_OFS = 8'h38;
  localparam logic [7:0] SMPG_MON2_OUT_OFS = 8'h3C;
  // control register fields
  localparam int SMPG_CTRL_POWER_BIT = 0;
  localparam int SMPG_CTRL_MODE_LSB = 1;
  localparam int SMPG_CTRL_ALM_CLR_BIT = 3;
  // status bits, same layout in the mask register
  localparam int SMPG_ST_OVF_BIT = 0;
  localparam int SMPG_ST_SON_BIT = 1;
  localparam int SMPG_ST_SPD_BIT = 2;
  localparam int SMPG_ST_W = 3;
  // control modes
  typedef enum logic [1:0] {SMPG_MODE_SPEED, SMPG_MODE_POSITION, SMPG_MODE_TORQUE} smpg_mode_t;
  // setting ranges and reset values
  localparam logic signed [15:0] SMPG_SET_MIN = -16'sd10000;
  localparam logic signed [15:0] SMPG_SET_MAX = 16'sd10000;
  localparam logic signed [15:0] SMPG_OFFSET_RST = 16'sh0000;
  localparam logic signed [15:0] SMPG_MULT_RST = 16'sd100;
  localparam logic [31:0] SMPG_MULT_UNITY = 32'd100;
  localparam logic [31:0] SMPG_LEVEL_MIN = 32'd1;
  localparam logic [31:0] SMPG_LEVEL_MAX = 32'd1073741823;
  localparam logic [31:0] SMPG_LEVEL_RST = 32'd5242880;
  localparam logic [13:0] SMPG_SPEED_MAX = 14'd10000;
  localparam logic [13:0] SMPG_SPEED_RST = 14'd10000;
  // signal selection codes
  localparam logic [3:0] SMPG_SEL_MAX = 4'hD;
  localparam logic [3:0] SMPG_SEL_POS_ERR = 4'h3;
  localparam logic [3:0] SMPG_SEL1_RST = 4'h2;
  localparam logic [3:0] SMPG_SEL2_RST = 4'h0;
  localparam int SMPG_NSIG = 14;
  // converter scaling: full scale +-10.24 V, so 0.1 V is 320 codes
  localparam int SMPG_DAC_W = 16;
  localparam logic signed [31:0] SMPG_OFFSET_CODES = 32'sd320;
  localparam logic signed [31:0] SMPG_DAC_MAX = 32'sd32767;
  localparam logic signed [31:0] SMPG_DAC_MIN = -32'sd32768;
  localparam logic signed [15:0] SMPG_LINEAR_CODES = 16'sd25600;
endpackage : smpg_pkg
